// ===== mdc_dma.sv
`timescale 1ns/1ps
`include "mdc_consts.svh"
// Memory-mapped DMA engine: read master, FIFO, write master
module mdc_dma #(
  parameter bit       BURST_EN = `MDC_BURST_ON,
  parameter bit [4:0] SIZE_EN  = `MDC_SIZES_ALL,
  parameter bit       FIFO_MEM = `MDC_FIFO_MEM
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // Control
  input  wire logic                   go,
  input  wire logic [`MDC_ADDR_W-1:0] read_start_addr,
  input  wire logic [`MDC_ADDR_W-1:0] write_start_addr,
  input  wire logic [`MDC_LEN_W-1:0]  length_bytes,
  input  wire mdc_pkg::mdc_size_t     size_sel,
  input  wire logic                   fixed_read_address_bit,
  input  wire logic                   fixed_write_address_bit,
  input  wire logic                   irq_enable,
  input  wire logic                   read_eop_enable,
  input  wire logic                   write_eop_enable,
  // Status
  output      logic                   busy,
  output      logic                   done,
  output      logic                   ended_by_eop,
  output      logic [`MDC_LEN_W-1:0]  length_left,
  output      logic                   irq,
  // Read master
  output      logic [`MDC_ADDR_W-1:0] rd_address,
  output      logic                   rd_read,
  input  wire logic [`MDC_DATA_W-1:0] rd_readdata,
  input  wire logic                   rd_waitrequest,
  input  wire logic                   rd_readyfordata,
  input  wire logic                   rd_endofpacket,
  output      logic [`MDC_BURST_W-1:0] rd_burstcount,
  // Write master
  output      logic [`MDC_ADDR_W-1:0] wr_address,
  output      logic                   wr_write,
  output      logic [`MDC_DATA_W-1:0] wr_writedata,
  output      logic [`MDC_BE_W-1:0]   wr_byteenable,
  input  wire logic                   wr_waitrequest,
  input  wire logic                   wr_readyfordata,
  input  wire logic                   wr_endofpacket,
  output      logic [`MDC_BURST_W-1:0] wr_burstcount
);
  mdc_pkg::mdc_state_t    state_reg;
  mdc_pkg::mdc_state_t    state_next;
  logic [2:0]             size_reg;
  logic                   rfix_reg;
  logic                   wfix_reg;
  logic                   irq_en_reg;
  logic                   reop_en_reg;
  logic                   weop_en_reg;
  logic [`MDC_LEN_W-1:0]  rd_left_reg;
  logic [`MDC_LEN_W-1:0]  wr_left_reg;
  logic [`MDC_LEN_W-1:0]  len_reg;
  logic                   rd_stop_reg;
  logic                   done_reg;
  logic                   eop_reg;
  logic                   irq_reg;
  logic                   start;
  logic                   size_ok;
  logic                   rd_take;
  logic                   wr_take;
  logic                   finish;
  logic                   fin_count;
  logic                   fin_reop;
  logic                   fin_weop;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [`MDC_DATA_W-1:0] fifo_out_data;
  logic [`MDC_DATA_W-1:0] rd_lane0;
  logic [`MDC_LEN_W-1:0]  step_bytes;
  logic [`MDC_BE_W-1:0]   be_base;
  logic [6:0]             rd_shift;
  logic [6:0]             wr_shift;

  // ----------------------------------------------------------------
  // Start and size decode
  // ----------------------------------------------------------------
  // A width built out is refused at go, so it needs no lane logic
  assign size_ok = SIZE_EN[size_sel];
  assign start   = go && (state_reg == mdc_pkg::MDC_IDLE) && size_ok;
  assign step_bytes = `MDC_LEN_W'(1) << size_reg;
  // One enable bit per byte of the beat, built in 17 bits so a quadword fits
  assign be_base    = `MDC_BE_W'((17'h0_0001 << (5'h01 << size_reg)) - 17'h0_0001);

  // ----------------------------------------------------------------
  // Address generators
  // ----------------------------------------------------------------
  mdc_addr_step u_rd_addr (
    .clk        (clk),
    .nrst       (nrst),
    .load       (start),
    .start_addr (read_start_addr),
    .advance    (rd_take),
    .fixed      (rfix_reg),
    .size_log2  (size_reg),
    .addr       (rd_address)
  );

  mdc_addr_step u_wr_addr (
    .clk        (clk),
    .nrst       (nrst),
    .load       (start),
    .start_addr (write_start_addr),
    .advance    (wr_take),
    .fixed      (wfix_reg),
    .size_log2  (size_reg),
    .addr       (wr_address)
  );

  // ----------------------------------------------------------------
  // Read master
  // ----------------------------------------------------------------
  // Reads only while the FIFO has space, so a push is never refused
  assign rd_read = (state_reg == mdc_pkg::MDC_RUN) && !rd_stop_reg &&
                   (rd_left_reg != '0) && fifo_in_ready && rd_readyfordata;
  assign rd_take = rd_read && !rd_waitrequest;
  // Byte lanes of the source address are moved down to lane zero
  assign rd_shift = {rd_address[`MDC_LANE_W-1:0], 3'h0};
  assign rd_lane0 = rd_readdata >> rd_shift;

  mdc_fifo #(
    .USE_MEM (FIFO_MEM)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .flush     (start),
    .in_valid  (rd_take),
    .in_ready  (fifo_in_ready),
    .in_data   (rd_lane0),
    .out_valid (fifo_out_valid),
    .out_ready (wr_take),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Write master
  // ----------------------------------------------------------------
  // Driven by FIFO data alone, whatever the read master is doing
  assign wr_write = (state_reg == mdc_pkg::MDC_RUN) && fifo_out_valid &&
                    (wr_left_reg != '0) && wr_readyfordata;
  assign wr_take  = wr_write && !wr_waitrequest;
  assign wr_shift = {wr_address[`MDC_LANE_W-1:0], 3'h0};
  assign wr_writedata  = fifo_out_data << wr_shift;
  assign wr_byteenable = be_base << wr_address[`MDC_LANE_W-1:0];

  // Burst counts in beats; tied to one when bursts are built out
  assign rd_burstcount = BURST_EN ? `MDC_BURST_W'(len_reg >> size_reg) :
                                    `MDC_BURST_W'(1);
  assign wr_burstcount = rd_burstcount;

  // ----------------------------------------------------------------
  // Termination
  // ----------------------------------------------------------------
  assign fin_count = wr_take && (wr_left_reg <= step_bytes);
  assign fin_weop  = wr_take && weop_en_reg && wr_endofpacket;
  // A source end lets the already fetched data drain out first
  assign fin_reop  = rd_stop_reg && !fifo_out_valid;
  assign finish    = (state_reg == mdc_pkg::MDC_RUN) &&
                     (fin_count || fin_weop || fin_reop || (wr_left_reg == '0));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mdc_pkg::MDC_IDLE: begin
        if (start) begin
          state_next = mdc_pkg::MDC_RUN;
        end
      end
      mdc_pkg::MDC_RUN: begin
        if (finish) begin
          state_next = mdc_pkg::MDC_IDLE;
        end
      end
      default: begin
        state_next = mdc_pkg::MDC_IDLE;
      end
    endcase
  end

  // Configuration captured at go so mid-run changes do no harm
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      size_reg    <= 3'h0;
      rfix_reg    <= 1'b0;
      wfix_reg    <= 1'b0;
      irq_en_reg  <= 1'b0;
      reop_en_reg <= 1'b0;
      weop_en_reg <= 1'b0;
      len_reg     <= `MDC_LEN_RST;
    end else if (start) begin
      size_reg    <= size_sel;
      rfix_reg    <= fixed_read_address_bit;
      wfix_reg    <= fixed_write_address_bit;
      irq_en_reg  <= irq_enable;
      reop_en_reg <= read_eop_enable;
      weop_en_reg <= write_eop_enable;
      len_reg     <= length_bytes;
    end
  end

  // Byte counters for each master
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= mdc_pkg::MDC_IDLE;
      rd_left_reg <= `MDC_LEN_RST;
      wr_left_reg <= `MDC_LEN_RST;
      rd_stop_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start) begin
        rd_left_reg <= length_bytes;
        wr_left_reg <= length_bytes;
        rd_stop_reg <= 1'b0;
      end else begin
        if (rd_take) begin
          rd_left_reg <= (rd_left_reg > step_bytes) ? rd_left_reg - step_bytes : '0;
        end
        if (wr_take) begin
          wr_left_reg <= (wr_left_reg > step_bytes) ? wr_left_reg - step_bytes : '0;
        end
        if (rd_take && reop_en_reg && rd_endofpacket) begin
          rd_stop_reg <= 1'b1;
        end
      end
    end
  end

  // Status flags; a new go clears them, completion sets done and loads eop and irq
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_reg <= 1'b0;
      eop_reg  <= 1'b0;
      irq_reg  <= 1'b0;
    end else if (finish) begin
      done_reg <= 1'b1;
      eop_reg  <= (fin_weop || fin_reop) && !fin_count;
      irq_reg  <= irq_en_reg;
    end else if (start) begin
      done_reg <= 1'b0;
      eop_reg  <= 1'b0;
      irq_reg  <= 1'b0;
    end
  end

  assign busy         = (state_reg == mdc_pkg::MDC_RUN);
  assign done         = done_reg;
  assign ended_by_eop = eop_reg;
  assign length_left  = wr_left_reg;
  assign irq          = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_FIFO_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    (busy && fifo_out_valid && wr_left_reg != '0 && wr_readyfordata) |-> wr_write)
    else $error("write held back with data in fifo");
  AST_RD_STALL: assert property (@(posedge clk) disable iff (!nrst)
    (rd_read && rd_waitrequest) |=> $stable(rd_address))
    else $error("read address moved under stall");
  AST_WR_STALL: assert property (@(posedge clk) disable iff (!nrst)
    (wr_write && wr_waitrequest) |=> $stable(wr_address) && $stable(wr_writedata))
    else $error("write changed under stall");
  AST_NOT_READY: assert property (@(posedge clk) disable iff (!nrst)
    !rd_readyfordata |-> !rd_read)
    else $error("read while slave not ready");
  AST_COUNT_END: assert property (@(posedge clk) disable iff (!nrst)
    fin_count |=> !busy ##0 done)
    else $error("byte count end missed");
  AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!nrst)
    (finish && !irq_en_reg) |=> !irq)
    else $error("irq raised while disabled");
  AST_IRQ_SET: assert property (@(posedge clk) disable iff (!nrst)
    (finish && irq_en_reg) |=> irq [*2] or (irq ##1 !irq))
    else $error("irq not raised at end");
  AST_GO_START: assert property (@(posedge clk) disable iff (!nrst)
    start |=> busy && rd_address == $past(read_start_addr) && !done)
    else $error("go did not start transfer");
  AST_BURST: assert property (@(posedge clk) disable iff (!nrst)
    (BURST_EN && busy) |-> rd_burstcount == `MDC_BURST_W'(len_reg >> size_reg))
    else $error("burst count wrong");
  AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!nrst)
    !busy |-> !rd_read && !wr_write)
    else $error("master active while idle");
endmodule

// ===== mdc_consts.svh
// How it works
// - Source and destination addresses are byte addresses.
// - Both masters are as wide as widest slave.
// - Burst count equals length over bytes per beat.
// - Two-deep FIFO; writes follow FIFO data only.
// - Both masters obey slave stalls and early ends.
// - Memory addresses advance one transfer width per access.
// - Fixed-address bits force zero increment, highest priority.
// - Increment follows size: 1, 2, 4, 8, 16.
// - Fixed mode holds the peripheral address all transaction.
// - Length register width is a 1..32 build parameter.
// - Default length width covers full slave span.
// - Build option enables bursts; burst count is cut to MDC_BURST_W bits, not capped.
// - Build option picks flip-flop or memory FIFO.
// - Each transfer width can be built in or out.
// - One control port, two master ports, nothing else.
// - End on byte count or enabled end-of-packet.
// - Interrupt at end only when enabled.
// - Go bit starts the transaction after setup.
`ifndef MDC_CONSTS_SVH
`define MDC_CONSTS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define MDC_DATA_W    128
`define MDC_BE_W      16
`define MDC_LANE_W    4
`define MDC_ADDR_W    32
`define MDC_LEN_W     32
`define MDC_FIFO_D    2
`define MDC_BURST_W   11
`define MDC_MAX_BURST 1024

// ----------------------------------------------------------------
// Build options and reset values
// ----------------------------------------------------------------
`define MDC_SIZES_ALL   5'h1f
`define MDC_BURST_ON    1'b0
`define MDC_FIFO_MEM    1'b0
`define MDC_ADDR_RST    32'h0000_0000
`define MDC_LEN_RST     32'h0000_0000
`define MDC_INCR_ZERO   5'h00

`endif

// ===== mdc_pkg.sv
package mdc_pkg;
  // Transfer width, encoded as log2 of bytes per transfer
  typedef enum logic [2:0] {
    MDC_BYTE,
    MDC_HALF,
    MDC_WORD,
    MDC_DWORD,
    MDC_QWORD
  } mdc_size_t;

  typedef enum logic [0:0] {
    MDC_IDLE,
    MDC_RUN
  } mdc_state_t;
endpackage

// ===== mdc_addr_step.sv
`timescale 1ns/1ps
`include "mdc_consts.svh"
// Address counter for one master: loads a byte address, then steps
module mdc_addr_step (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   load,
  input  wire logic [`MDC_ADDR_W-1:0] start_addr,
  input  wire logic                   advance,
  input  wire logic                   fixed,
  input  wire logic [2:0]             size_log2,
  output      logic [`MDC_ADDR_W-1:0] addr
);
  logic [`MDC_ADDR_W-1:0] addr_reg;
  logic [`MDC_ADDR_W-1:0] addr_next;
  logic [4:0]             incr;

  // ----------------------------------------------------------------
  // Increment select
  // ----------------------------------------------------------------
  // Fixed bit wins over size so a peripheral register is never walked
  assign incr = fixed ? `MDC_INCR_ZERO : 5'(5'h01 << size_log2);
  assign addr_next = load ? start_addr :
                     (advance ? addr_reg + `MDC_ADDR_W'(incr) : addr_reg);
  assign addr = addr_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= `MDC_ADDR_RST;
    end else begin
      addr_reg <= addr_next;
    end
  end

  AST_FIXED_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    (fixed && !load) |=> $stable(addr_reg))
    else $error("fixed address moved");
  AST_STEP: assert property (@(posedge clk) disable iff (!nrst)
    (advance && !load && !fixed) |=>
      addr_reg == $past(addr_reg) + (`MDC_ADDR_W'(1) << $past(size_log2)))
    else $error("address step wrong");
endmodule

// ===== mdc_fifo.sv
`timescale 1ns/1ps
`include "mdc_consts.svh"
// Shallow FIFO between the read and write masters
module mdc_fifo #(
  parameter bit USE_MEM = `MDC_FIFO_MEM
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   flush,
  input  wire logic                   in_valid,
  output      logic                   in_ready,
  input  wire logic [`MDC_DATA_W-1:0] in_data,
  output      logic                   out_valid,
  input  wire logic                   out_ready,
  output      logic [`MDC_DATA_W-1:0] out_data
);
  logic [0:0] wp_reg;
  logic [0:0] rp_reg;
  logic [1:0] cnt_reg;
  logic       push;
  logic       pop;

  assign in_ready  = (cnt_reg != 2'(`MDC_FIFO_D));
  assign out_valid = (cnt_reg != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  generate
    if (USE_MEM) begin : g_mem
      // Array left for block-memory mapping; same read timing kept
      logic [`MDC_DATA_W-1:0] ram [`MDC_FIFO_D];
      always_ff @(posedge clk) begin
        if (push) begin
          ram[wp_reg] <= in_data;
        end
      end
      assign out_data = ram[rp_reg];
    end else begin : g_reg
      // One flop per stored bit; costly at 128 bits but no memory
      logic [`MDC_DATA_W-1:0] regs [`MDC_FIFO_D];
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          regs[0] <= '0;
          regs[1] <= '0;
        end else if (push) begin
          regs[wp_reg] <= in_data;
        end
      end
      assign out_data = regs[rp_reg];
    end
  endgenerate

  // Pointers; flush empties the FIFO before each new transaction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (flush) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      wp_reg  <= wp_reg + 1'(push);
      rp_reg  <= rp_reg + 1'(pop);
      cnt_reg <= cnt_reg + 2'(push) - 2'(pop);
    end
  end

  AST_FLUSH_EMPTY: assert property (@(posedge clk) disable iff (!nrst)
    flush |=> !out_valid)
    else $error("fifo not empty after flush");
endmodule

// ===== mdc_slave_model.sv
`timescale 1ns/1ps
`include "mdc_consts.svh"
// Far side of both masters: a source memory and a destination that accepts writes without storing them
module mdc_slave_model (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   clr,
  input  wire logic                   slow,
  input  wire logic [7:0]             rd_eop_at,
  input  wire logic [7:0]             wr_eop_at,
  input  wire logic [`MDC_ADDR_W-1:0] rd_address,
  input  wire logic                   rd_read,
  output      logic [`MDC_DATA_W-1:0] rd_readdata,
  output      logic                   rd_waitrequest,
  output      logic                   rd_readyfordata,
  output      logic                   rd_endofpacket,
  input  wire logic                   wr_write,
  output      logic                   wr_waitrequest,
  output      logic                   wr_readyfordata,
  output      logic                   wr_endofpacket
);
  logic [3:0]             tick_reg;
  logic [7:0]             rd_cnt_reg;
  logic [7:0]             wr_cnt_reg;
  logic [`MDC_DATA_W-1:0] line;

  // Byte at address a holds a[7:0] ^ 5a, laid out in its own lane
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      line[8*i+:8] = {rd_address[7:4], 4'(i)} ^ 8'h5a;
    end
  end

  // Slow mode stalls on alternate cycles; data off-accept is inverted, not held
  assign rd_waitrequest  = slow & tick_reg[0];
  assign wr_waitrequest  = slow & ~tick_reg[0];
  assign rd_readyfordata = ~(slow & (tick_reg[1:0] == 2'h3));
  assign wr_readyfordata = ~(slow & (tick_reg[2:0] == 3'h6));
  assign rd_readdata     = (rd_read && !rd_waitrequest) ? line : ~line;
  assign rd_endofpacket  = (rd_eop_at != 8'h00) && (rd_cnt_reg == rd_eop_at - 8'h01);
  assign wr_endofpacket  = (wr_eop_at != 8'h00) && (wr_cnt_reg == wr_eop_at - 8'h01);

  // Counts of accepted transfers, cleared on every start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_reg   <= 4'h0;
      rd_cnt_reg <= 8'h00;
      wr_cnt_reg <= 8'h00;
    end else begin
      tick_reg   <= tick_reg + 4'h1;
      rd_cnt_reg <= clr ? 8'h00 : rd_cnt_reg + 8'(rd_read & ~rd_waitrequest);
      wr_cnt_reg <= clr ? 8'h00 : wr_cnt_reg + 8'(wr_write & ~wr_waitrequest);
    end
  end
endmodule

// ===== memory_mapped_dma_controller_test.sv
`timescale 1ns/1ps
`include "mdc_consts.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module memory_mapped_dma_controller_test;
  logic clk, nrst, go, fr_bit, fw_bit, irq_enable, read_eop_enable, write_eop_enable, slow;
  logic [31:0] read_start_addr, write_start_addr, length_bytes, length_left, rd_address;
  logic [31:0] wr_address, seed, t_ra, t_wa, ea, ra;
  logic [127:0] rd_readdata, wr_writedata;
  logic [15:0] wr_byteenable;
  logic [10:0] rd_burstcount, wr_burstcount;
  logic [7:0] rd_eop_at, wr_eop_at;
  logic busy, done, ended_by_eop, irq, rd_read, rd_wait, rd_rfd, rd_eop;
  logic wr_write, wr_wait, wr_rfd, wr_eop, watch;
  mdc_pkg::mdc_size_t size_sel;
  int error_cnt, comparisons, t_nb, t_ri, t_wi, t_len, t_sz, wcount, rcount;

  always #2 clk = ~clk;

  mdc_dma #(.BURST_EN(1'b1)) dut (
    .clk(clk), .nrst(nrst), .go(go), .read_start_addr(read_start_addr),
    .write_start_addr(write_start_addr), .length_bytes(length_bytes), .size_sel(size_sel),
    .fixed_read_address_bit(fr_bit), .fixed_write_address_bit(fw_bit),
    .irq_enable(irq_enable), .read_eop_enable(read_eop_enable),
    .write_eop_enable(write_eop_enable), .busy(busy), .done(done),
    .ended_by_eop(ended_by_eop), .length_left(length_left), .irq(irq),
    .rd_address(rd_address), .rd_read(rd_read), .rd_readdata(rd_readdata),
    .rd_waitrequest(rd_wait), .rd_readyfordata(rd_rfd), .rd_endofpacket(rd_eop),
    .rd_burstcount(rd_burstcount), .wr_address(wr_address), .wr_write(wr_write),
    .wr_writedata(wr_writedata), .wr_byteenable(wr_byteenable), .wr_waitrequest(wr_wait),
    .wr_readyfordata(wr_rfd), .wr_endofpacket(wr_eop), .wr_burstcount(wr_burstcount));

  // Far-end counters restart on any go while not busy; a go during a run must not disturb them
  mdc_slave_model far_end (
    .clk(clk), .nrst(nrst), .clr(go && !busy), .slow(slow), .rd_eop_at(rd_eop_at),
    .wr_eop_at(wr_eop_at), .rd_address(rd_address), .rd_read(rd_read),
    .rd_readdata(rd_readdata), .rd_waitrequest(rd_wait), .rd_readyfordata(rd_rfd),
    .rd_endofpacket(rd_eop), .wr_write(wr_write), .wr_waitrequest(wr_wait),
    .wr_readyfordata(wr_rfd), .wr_endofpacket(wr_eop));

  // --------------------------------------------------------------
  // Expectation helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction

  function automatic logic [15:0] exp_be(input logic [3:0] lane, input int nb);
    return 16'(((1 << nb) - 1) << lane);
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Bus monitor: every accepted beat is checked against the plan while watch is set
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (nrst && watch && rd_read && !rd_wait) begin
      `CHK("rd_address", t_ra + 32'(rcount * t_ri), rd_address)
      `CHK("rd_burstcount", 11'(t_len >> t_sz), rd_burstcount)
      rcount++;
    end
    if (nrst && watch && wr_write && !wr_wait) begin
      ea = t_wa + 32'(wcount * t_wi);
      ra = t_ra + 32'(wcount * t_ri);
      `CHK("wr_address", ea, wr_address)
      `CHK("wr_byteenable", exp_be(ea[3:0], t_nb), wr_byteenable)
      `CHK("wr_burstcount", 11'(t_len >> t_sz), wr_burstcount)
      for (int j = 0; j < t_nb; j++)
        `CHK("wr_writedata", mem_byte(ra + 32'(j)), wr_writedata[8*(ea[3:0]+j)+:8])
      wcount++;
    end
    // A slave that is not ready must stop the master in the same cycle
    if (nrst && busy && !rd_rfd) `CHK("rd_read", 1'b0, rd_read)
    if (nrst && busy && !wr_rfd) `CHK("wr_write", 1'b0, wr_write)
  end

  // One transaction: sz size, fr/fw fixed bits, n beats, sl slow far end
  task automatic run(input int sz, input bit fr, input bit fw, input int n, input bit sl,
                     input int reop, input int weop, input int exp_n);
    int k;
    @(negedge clk);
    t_sz = sz;
    t_nb = 1 << sz;
    t_ri = fr ? 0 : t_nb;
    t_wi = fw ? 0 : t_nb;
    // Engine is at least as wide as the programming master, so no address scaling
    t_ra = (32'($random(seed)) & 32'h0fff) & ~32'(t_nb - 1);
    t_wa = (32'h0001_0000 | (32'($random(seed)) & 32'hfff)) & ~32'(t_nb - 1);
    t_len = n * t_nb;
    wcount = 0;
    rcount = 0;
    watch = 1'b1;
    read_start_addr = t_ra;
    write_start_addr = t_wa;
    length_bytes = 32'(t_len);
    size_sel = mdc_pkg::mdc_size_t'(3'(sz));
    fr_bit = fr;
    fw_bit = fw;
    irq_enable = 1'($random(seed));
    read_eop_enable = (reop != 0);
    write_eop_enable = (weop != 0);
    rd_eop_at = 8'(reop);
    wr_eop_at = 8'(weop);
    slow = sl;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    `CHK("busy", 1'b1, busy)
    // A second start while running is ignored; bad addresses must never show
    read_start_addr = ~t_ra;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    read_start_addr = t_ra;
    for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge clk);
    if (busy !== 1'b0) begin
      error_cnt++;
      $display("[ERR] busy still set after bound");
      report_and_stop();
    end
    `CHK("write count", exp_n, wcount)
    `CHK("done", 1'b1, done)
    `CHK("irq", irq_enable, irq)
    `CHK("ended_by_eop", (reop != 0) || (weop != 0), ended_by_eop)
    if (reop == 0 && weop == 0) `CHK("length_left", 32'h0, length_left)
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    int s;
    int n;
    seed = 32'hcba5e4cb;
    clk = 1'b0;
    {nrst, go, fr_bit, fw_bit, irq_enable, read_eop_enable, write_eop_enable, slow} = 8'h00;
    {read_start_addr, write_start_addr, length_bytes} = 96'h0;
    {rd_eop_at, wr_eop_at} = 16'h0000;
    size_sel = mdc_pkg::MDC_BYTE;
    watch = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    `CHK("busy", 1'b0, busy)
    // Every width, incrementing, then fixed, then each side fixed alone
    for (s = 0; s < 5; s++) run(s, 1'b0, 1'b0, 6, 1'b0, 0, 0, 6);
    for (s = 0; s < 5; s++) run(s, 1'b1, 1'b1, 5, 1'b1, 0, 0, 5);
    run(2, 1'b1, 1'b0, 4, 1'b0, 0, 0, 4);
    run(3, 1'b0, 1'b1, 4, 1'b1, 0, 0, 4);
    run(4, 1'b0, 1'b0, 1, 1'b0, 0, 0, 1);
    // Random mixes of width, length and far-end pace
    repeat (8) begin
      s = int'($unsigned($random(seed)) % 5);
      n = 1 + int'($unsigned($random(seed)) % 9);
      run(s, 1'($random(seed)), 1'($random(seed)), n, 1'($random(seed)), 0, 0, n);
    end
    // Early ends from the destination and from the source
    run(2, 1'b0, 1'b0, 10, 1'b1, 0, 3, 3);
    run(1, 1'b0, 1'b0, 10, 1'b0, 4, 0, 4);
    // Reset in mid-run; the next transfer must not see stale FIFO data
    watch = 1'b0;
    length_bytes = 32'h40;
    size_sel = mdc_pkg::MDC_BYTE;
    read_eop_enable = 1'b0;
    write_eop_enable = 1'b0;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b0;
    #1;
    `CHK("busy", 1'b0, busy)
    `CHK("rd_read", 1'b0, rd_read)
    `CHK("length_left", 32'h0, length_left)
    @(negedge clk);
    nrst = 1'b1;
    run(0, 1'b0, 1'b0, 3, 1'b0, 0, 0, 3);
    report_and_stop();
  end
endmodule
